// ===== common/clk_stop_pkg.sv
// package: register layout, reset values and pin group widths for module clock stop and standby pins
// assumes byte-wide register port, single clock domain
package clk_stop_pkg;
	localparam logic [7:0] CTRL2_OFFSET = 8'h00;
	localparam logic [7:0] PIN_CTRL_OFFSET = 8'h01;
	localparam logic [7:0] CTRL3_OFFSET = 8'h02;
	localparam logic [7:0] CTRL2_RESET = 8'h00;
	localparam logic [7:0] PIN_CTRL_RESET = 8'h00;
	localparam logic [7:0] CTRL3_RESET = 8'h00;
	localparam int BIT_DEBUG_STOP = 7;
	localparam int BIT_BREAK_STOP = 6;
	localparam int BIT_DMA_STOP = 5;
	localparam int BIT_XFER_STOP = 1;
	localparam logic [7:0] CTRL2_WMASK = 8'hE2;
	localparam int BIT_D_LOW_SEL = 0;
	localparam int BIT_E_LOW_SEL = 1;
	localparam int BIT_E_HIGH_SEL = 2;
	localparam logic [7:0] PIN_CTRL_WMASK = 8'h07;
	localparam int BIT_OUT_FLOAT = 0;
	localparam logic [7:0] CTRL3_WMASK = 8'h01;
	localparam int D_LOW_PINS = 6;
	localparam int E_LOW_PINS = 6;
	localparam int E_HIGH_PINS = 6;
	localparam int GROUPS = 3;
	localparam int GROUP_PINS = 6;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} reg_req_t;

	typedef struct packed {
		logic [GROUP_PINS-1:0] out;
		logic [GROUP_PINS-1:0] oe;
	} pin_drive_t;
endpackage

// ===== logic/clk_stop_ctrl.sv
// module clock stop control and software standby pin state control
// assumes synchronous byte register port, standby entry signalled by standby_active
// Notes on behaviour
// - break stop bit one halts break controller clock, zero keeps it running
// - bit five halts dma controller clock when one, runs when zero
// - bit one halts data transfer controller clock when one
// - bits four to two read zero; software writes zero
// - bit zero reads zero; software writes zero
// - standby: group select zero floats pins, one floats inputs and holds outputs
// - held outputs float instead while standby output float bit is one
// - control registers cleared by power-on reset, kept through standby
`timescale 1ns/1ps
`default_nettype none
module clk_stop_ctrl
	import clk_stop_pkg::*;
#(
	parameter int PINS = clk_stop_pkg::GROUP_PINS
) (
	// clock and power-on reset
	input wire logic clk_sys,
	input wire logic rst_b,
	// register port
	input wire clk_stop_pkg::reg_req_t req,
	output logic [7:0] rdata,
	// power-down state
	input wire logic standby_active,
	// gated module clocks
	output logic clk_debug,
	output logic clk_break,
	output logic clk_dma,
	output logic clk_xfer,
	// port groups: d low, e low, e high; functional drive in, pin drive out
	input wire clk_stop_pkg::pin_drive_t [GROUPS-1:0] func_drive,
	output clk_stop_pkg::pin_drive_t [GROUPS-1:0] pin_drive
);
	import clk_stop_pkg::*;

	logic [7:0] ctrl2;
	logic [7:0] pin_ctrl;
	logic [7:0] ctrl3;
	logic [7:0] next_rdata;
	logic [3:0] stop_req;
	logic [3:0] stop_latch;
	logic [3:0] gclk;
	logic [GROUPS-1:0] group_hold;
	pin_drive_t [GROUPS-1:0] held;
	logic standby_q;

	wire wr_ctrl2 = req.wr && (req.addr == CTRL2_OFFSET);
	wire wr_pin = req.wr && (req.addr == PIN_CTRL_OFFSET);
	wire wr_ctrl3 = req.wr && (req.addr == CTRL3_OFFSET);
	wire rd_ctrl2 = req.rd && (req.addr == CTRL2_OFFSET);
	wire rd_pin = req.rd && (req.addr == PIN_CTRL_OFFSET);
	wire rd_ctrl3 = req.rd && (req.addr == CTRL3_OFFSET);
	wire out_float = ctrl3[BIT_OUT_FLOAT];

	// reserved bits masked on write so they read zero
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			ctrl2 <= CTRL2_RESET;
			pin_ctrl <= PIN_CTRL_RESET;
			ctrl3 <= CTRL3_RESET;
		end else begin
			if (wr_ctrl2)
				ctrl2 <= req.wdata & CTRL2_WMASK;
			if (wr_pin)
				pin_ctrl <= req.wdata & PIN_CTRL_WMASK;
			if (wr_ctrl3)
				ctrl3 <= req.wdata & CTRL3_WMASK;
		end
	end

	assign next_rdata = rd_ctrl2 ? ctrl2 : rd_pin ? pin_ctrl : rd_ctrl3 ? ctrl3 : 8'h00;

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b)
			rdata <= 8'h00;
		else
			rdata <= next_rdata;
	end

	// clock gating: enable latched while clock low
	assign stop_req = {ctrl2[BIT_DEBUG_STOP], ctrl2[BIT_BREAK_STOP], ctrl2[BIT_DMA_STOP], ctrl2[BIT_XFER_STOP]};

	always_latch begin
		if (!clk_sys)
			stop_latch <= stop_req;
	end

	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : gate
			assign gclk[g] = clk_sys & ~stop_latch[g];
		end
	endgenerate

	assign clk_debug = gclk[3];
	assign clk_break = gclk[2];
	assign clk_dma = gclk[1];
	assign clk_xfer = gclk[0];

	// capture output levels on standby entry
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			standby_q <= 1'b0;
			held <= '0;
		end else begin
			standby_q <= standby_active;
			if (!standby_q || !standby_active)
				held <= func_drive;
		end
	end

	assign group_hold = pin_ctrl[GROUPS-1:0];

	generate
		for (g = 0; g < GROUPS; g++) begin : grp
			always_comb begin
				if (!standby_active) begin
					pin_drive[g] = func_drive[g];
				end else if (group_hold[g] && !out_float) begin
					pin_drive[g].out = held[g].out;
					pin_drive[g].oe = held[g].oe;
				end else begin
					pin_drive[g].out = '0;
					pin_drive[g].oe = '0;
				end
			end
		end
	endgenerate

	// assertions
	property p_reserved_zero;
		@(posedge clk_sys) disable iff (!rst_b)
		(ctrl2[4:2] == 3'h0) && !ctrl2[0];
	endproperty
	a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits not zero");

	property p_read_reserved;
		@(posedge clk_sys) disable iff (!rst_b)
		rd_ctrl2 |=> (rdata[4:2] == 3'h0) && !rdata[0];
	endproperty
	a_read_reserved: assert property (p_read_reserved) else $error("reserved bits read nonzero");

	property p_write_break;
		@(posedge clk_sys) disable iff (!rst_b)
		wr_ctrl2 |=> ctrl2[BIT_BREAK_STOP] == $past(req.wdata[BIT_BREAK_STOP]);
	endproperty
	a_write_break: assert property (p_write_break) else $error("break stop bit not stored");

	property p_dma_stopped;
		@(negedge clk_sys) disable iff (!rst_b)
		ctrl2[BIT_DMA_STOP] ##1 ctrl2[BIT_DMA_STOP] |-> !clk_dma;
	endproperty
	a_dma_stopped: assert property (p_dma_stopped) else $error("dma clock running while stopped");

	property p_xfer_running;
		@(negedge clk_sys) disable iff (!rst_b)
		!ctrl2[BIT_XFER_STOP] ##1 !ctrl2[BIT_XFER_STOP] |-> clk_xfer;
	endproperty
	a_xfer_running: assert property (p_xfer_running) else $error("transfer clock stopped");

	property p_float_group;
		@(posedge clk_sys) disable iff (!rst_b)
		standby_active && !group_hold[0] |-> pin_drive[0].oe == '0;
	endproperty
	a_float_group: assert property (p_float_group) else $error("unselected group drives in standby");

	property p_out_float;
		@(posedge clk_sys) disable iff (!rst_b)
		standby_active && out_float |-> (pin_drive[1].oe == '0) && (pin_drive[2].oe == '0);
	endproperty
	a_out_float: assert property (p_out_float) else $error("output driven with float bit set");

	property p_hold_stable;
		@(posedge clk_sys) disable iff (!rst_b)
		standby_active && standby_q && group_hold[1] && !out_float ##1 standby_active && group_hold[1] && !out_float
			|-> $stable(pin_drive[1].out);
	endproperty
	a_hold_stable: assert property (p_hold_stable) else $error("held output changed");

	property p_keep_value;
		@(posedge clk_sys) disable iff (!rst_b)
		!wr_ctrl2 |=> $stable(ctrl2);
	endproperty
	a_keep_value: assert property (p_keep_value) else $error("control changed without write");

	property p_dma_running;
		@(negedge clk_sys) disable iff (!rst_b)
		!ctrl2[BIT_DMA_STOP] ##1 !ctrl2[BIT_DMA_STOP] |-> clk_dma;
	endproperty
	a_dma_running: assert property (p_dma_running) else $error("dma clock stopped while enabled");

	property p_break_stopped;
		@(negedge clk_sys) disable iff (!rst_b)
		ctrl2[BIT_BREAK_STOP] ##1 ctrl2[BIT_BREAK_STOP] |-> !clk_break;
	endproperty
	a_break_stopped: assert property (p_break_stopped) else $error("break clock running while stopped");

	property p_break_running;
		@(negedge clk_sys) disable iff (!rst_b)
		!ctrl2[BIT_BREAK_STOP] ##1 !ctrl2[BIT_BREAK_STOP] |-> clk_break;
	endproperty
	a_break_running: assert property (p_break_running) else $error("break clock stopped while enabled");

	property p_xfer_stopped;
		@(negedge clk_sys) disable iff (!rst_b)
		ctrl2[BIT_XFER_STOP] ##1 ctrl2[BIT_XFER_STOP] |-> !clk_xfer;
	endproperty
	a_xfer_stopped: assert property (p_xfer_stopped) else $error("transfer clock running while stopped");

	property p_write_dma;
		@(posedge clk_sys) disable iff (!rst_b)
		wr_ctrl2 |=> ctrl2[BIT_DMA_STOP] == $past(req.wdata[BIT_DMA_STOP]);
	endproperty
	a_write_dma: assert property (p_write_dma) else $error("dma stop bit not stored");

	property p_write_xfer;
		@(posedge clk_sys) disable iff (!rst_b)
		wr_ctrl2 |=> ctrl2[BIT_XFER_STOP] == $past(req.wdata[BIT_XFER_STOP]);
	endproperty
	a_write_xfer: assert property (p_write_xfer) else $error("transfer stop bit not stored");

	property p_read_ctrl2;
		@(posedge clk_sys) disable iff (!rst_b)
		rd_ctrl2 |=> rdata == $past(ctrl2);
	endproperty
	a_read_ctrl2: assert property (p_read_ctrl2) else $error("stop control read back wrong");

	property p_read_pin;
		@(posedge clk_sys) disable iff (!rst_b)
		rd_pin |=> rdata == $past(pin_ctrl);
	endproperty
	a_read_pin: assert property (p_read_pin) else $error("pin control read back wrong");

	property p_read_ctrl3;
		@(posedge clk_sys) disable iff (!rst_b)
		rd_ctrl3 |=> rdata == $past(ctrl3);
	endproperty
	a_read_ctrl3: assert property (p_read_ctrl3) else $error("float control read back wrong");

	property p_write_select;
		@(posedge clk_sys) disable iff (!rst_b)
		wr_pin |=> group_hold == $past(req.wdata[GROUPS-1:0]);
	endproperty
	a_write_select: assert property (p_write_select) else $error("group select not stored");

	property p_write_float;
		@(posedge clk_sys) disable iff (!rst_b)
		wr_ctrl3 |=> out_float == $past(req.wdata[BIT_OUT_FLOAT]);
	endproperty
	a_write_float: assert property (p_write_float) else $error("float bit not stored");

	property p_pass_through;
		@(posedge clk_sys) disable iff (!rst_b)
		!standby_active |-> pin_drive == func_drive;
	endproperty
	a_pass_through: assert property (p_pass_through) else $error("pins not functional outside standby");

	property p_float_e_low;
		@(posedge clk_sys) disable iff (!rst_b)
		standby_active && !group_hold[1] |-> pin_drive[1].oe == '0;
	endproperty
	a_float_e_low: assert property (p_float_e_low) else $error("unselected group drives in standby");

	property p_float_e_high;
		@(posedge clk_sys) disable iff (!rst_b)
		standby_active && !group_hold[2] |-> pin_drive[2].oe == '0;
	endproperty
	a_float_e_high: assert property (p_float_e_high) else $error("unselected group drives in standby");

	property p_out_float_d;
		@(posedge clk_sys) disable iff (!rst_b)
		standby_active && out_float |-> pin_drive[0].oe == '0;
	endproperty
	a_out_float_d: assert property (p_out_float_d) else $error("output driven with float bit set");

	property p_hold_entry;
		@(posedge clk_sys) disable iff (!rst_b)
		!standby_active ##1 standby_active && group_hold[0] && !out_float |-> pin_drive[0] == $past(func_drive[0]);
	endproperty
	a_hold_entry: assert property (p_hold_entry) else $error("held level differs from entry level");

	property p_latch_follows;
		@(posedge clk_sys) disable iff (!rst_b)
		stop_latch == stop_req;
	endproperty
	a_latch_follows: assert property (p_latch_follows) else $error("gate enable not taken in low phase");

	property p_reset_clear;
		@(posedge clk_sys)
		!rst_b ##1 !rst_b |-> (ctrl2 == CTRL2_RESET) && (pin_ctrl == PIN_CTRL_RESET) && (ctrl3 == CTRL3_RESET);
	endproperty
	a_reset_clear: assert property (p_reset_clear) else $error("registers not cleared by reset");

	c_stop_dma: cover property (@(posedge clk_sys) disable iff (!rst_b) wr_ctrl2 ##1 ctrl2[BIT_DMA_STOP]);
	c_hold: cover property (@(posedge clk_sys) disable iff (!rst_b) standby_active && group_hold[2] && !out_float);
	c_float: cover property (@(posedge clk_sys) disable iff (!rst_b) standby_active && out_float);
	c_stop_break: cover property (@(posedge clk_sys) disable iff (!rst_b) wr_ctrl2 ##1 ctrl2[BIT_BREAK_STOP]);
	c_entry: cover property (@(posedge clk_sys) disable iff (!rst_b) !standby_active ##1 standby_active && group_hold[0]);
endmodule
`default_nettype wire

// ===== test/clk_stop_ctrl_tb_top.sv
// bench: register and pin model compared with the clock stop block
// assumes the block alone, inputs driven at rising edges
`timescale 1ns/1ps
`default_nettype none
module clk_stop_ctrl_tb_top;
	import clk_stop_pkg::*;
	logic clk_sys = 1'b0;
	logic rst_b = 1'b0;
	logic standby_active = 1'b0;
	reg_req_t req = '0;
	pin_drive_t [GROUPS-1:0] fd = '0;
	pin_drive_t [GROUPS-1:0] f1;
	pin_drive_t [GROUPS-1:0] pin_drive;
	logic [7:0] rdata;
	logic [3:0] ck;
	logic [7:0] m [4] = '{default: 8'h00};
	logic [7:0] wm [4] = '{CTRL2_WMASK, PIN_CTRL_WMASK, CTRL3_WMASK, 8'h00};
	logic [63:0] r;
	logic [5:0] eo;
	int error_cnt = 0;
	int tests_run = 0;
	int cyc = 0;
	always #2 clk_sys = ~clk_sys;
	clk_stop_ctrl clk_stop_ctrl_inst (.clk_sys(clk_sys), .rst_b(rst_b), .req(req), .rdata(rdata),
		.standby_active(standby_active), .clk_debug(ck[3]), .clk_break(ck[2]), .clk_dma(ck[1]),
		.clk_xfer(ck[0]), .func_drive(fd), .pin_drive(pin_drive));
	task automatic chk(input string n, input logic [35:0] e, input logic [35:0] s);
		tests_run++;
		if (s !== e) begin
			error_cnt++;
			$display("FAIL %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic wr(input logic [1:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		req <= '{{6'h00, a}, d, 1'b1, 1'b0};
		@(posedge clk_sys);
		req.wr <= 1'b0;
		m[a] = d & wm[a];
	endtask
	task automatic rd(input logic [1:0] a);
		@(posedge clk_sys);
		req <= '{{6'h00, a}, 8'h00, 1'b0, 1'b1};
		@(posedge clk_sys);
		req.rd <= 1'b0;
		#1 chk("rdata", 36'(m[a]), 36'(rdata));
	endtask
	task automatic wrap_up;
		if (error_cnt == 0 && tests_run > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 5000) begin
			error_cnt++;
			wrap_up;
		end
	end
	initial begin
		void'($urandom(32'h4f90));
		repeat (20) @(posedge clk_sys);
		rst_b <= 1'b1;
		for (int a = 0; a < 4; a++) rd(a[1:0]);
		for (int i = 0; i < 32; i++) begin
			wr(2'($urandom % 4), 8'($urandom));
			for (int a = 0; a < 4; a++) rd(a[1:0]);
			@(posedge clk_sys);
			#1 chk("clocks", 36'({~m[0][7], ~m[0][6], ~m[0][5], ~m[0][1]}), 36'(ck));
			r = {$urandom, $urandom};
			@(posedge clk_sys);
			fd <= r[35:0];
			@(posedge clk_sys);
			standby_active <= 1'b1;
			f1 = fd;
			for (int k = 0; k < 2; k++) begin
				@(posedge clk_sys);
				r = {$urandom, $urandom};
				fd <= r[35:0];
				#1 for (int g = 0; g < GROUPS; g++) begin
					eo = m[1][g] ? (f1[g].oe & {6{~m[2][0]}}) : 6'h00;
					chk("pin_oe", 36'(eo), 36'(pin_drive[g].oe));
					chk("pin_out", 36'(f1[g].out & eo), 36'(pin_drive[g].out & eo));
				end
			end
			@(posedge clk_sys);
			standby_active <= 1'b0;
			@(posedge clk_sys);
			#1 chk("pins", fd, pin_drive);
		end
		wr(2'h0, 8'hE2);
		@(posedge clk_sys);
		rst_b <= 1'b0;
		repeat (2) @(posedge clk_sys);
		rst_b <= 1'b1;
		m = '{default: 8'h00};
		for (int a = 0; a < 4; a++) rd(a[1:0]);
		@(posedge clk_sys);
		#1 chk("clocks", 36'({~m[0][7], ~m[0][6], ~m[0][5], ~m[0][1]}), 36'(ck));
		wrap_up;
	end
endmodule
`default_nettype wire
